// file: rtl/dodt_pkg.sv
// Overview of operation
// - Terminate DQ, strobe, mask lanes per organisation
// - No termination in DLL-disable mode
// - Ignore ODT in self refresh or all-off
// - Synchronous when DLL locked, else asynchronous
// - Nominal code enables; ODT pin switches it
// - Codes 110 and 111 never programmed; controller passes them on, DRAM end flags cfg_illegal
// - ODT low during reads and self refresh
// - ODT normally high during writes, optional
// - Nominal strength is 240 ohm divided
// - Nominal writes only divide by 2,4,6
// - Enable termination only after init, calibration
// - Sync turn-on CWL+AL-2 after ODT high
// - Sync turn-off CWL+AL-2 after ODT change
// - Off within half cycle after latency
// - Async switch 2 to 8.5 ns; model switches at the next 20 ns clock edge
// - ODT high at least 4 cycles
// - ODT high 6 cycles after BL8 write
// - Write strength only inside write burst
// - Dynamic enabled when either MR2 bit set
// - Switch to write strength WL-2 after write
// - Back to nominal ODTLoff plus 4 or 6
package dodt_pkg;
  localparam int NOM_W = 3;
  localparam int WRS_W = 2;
  localparam int CL_W = 4;
  localparam int LAT_W = 5;
  localparam int LAT_DEPTH = 32;
  localparam int CNT_W = 6;
  localparam int DIV_W = 4;
  localparam int OHM_W = 8;
  localparam int LANES = 6;
  localparam logic [LAT_W-1:0] ODTL_SUB = 5'h02;
  localparam logic [CNT_W-1:0] ODTH4 = 6'h04;
  localparam logic [CNT_W-1:0] ODTH8 = 6'h06;
  localparam int RZQ_OHM = 240;
  localparam logic [DIV_W-1:0] DIV_OFF = 4'h0;
  localparam logic [DIV_W-1:0] DIV2 = 4'h2;
  localparam logic [DIV_W-1:0] DIV4 = 4'h4;
  localparam logic [DIV_W-1:0] DIV6 = 4'h6;
  localparam logic [DIV_W-1:0] DIV8 = 4'h8;
  localparam logic [DIV_W-1:0] DIV12 = 4'hC;
  localparam int CLK_PERIOD_PS = 20000;
  localparam int ASYNC_MIN_PS = 2000;
  localparam int ASYNC_MAX_PS = 8500;
  localparam int ASYNC_CYC = (ASYNC_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LN_DQ = 0;
  localparam int LN_LDQS = 1;
  localparam int LN_LDM = 2;
  localparam int LN_TDQS = 3;
  localparam int LN_UDQS = 4;
  localparam int LN_UDM = 5;
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam int CFG_W = 18;
  localparam int CF_NOM = 0;
  localparam int CF_WRS = 3;
  localparam int CF_CWL = 5;
  localparam int CF_AL = 9;
  localparam int CF_DLLDIS = 13;
  localparam int CF_LOCK = 14;
  localparam int CF_X16 = 15;
  localparam int CF_TDQS = 16;
  localparam int CF_INIT = 17;
  localparam logic [CFG_W-1:0] CFG_RST = 18'h000A0;
  localparam int CM_WR = 0;
  localparam int CM_BL8 = 1;
  localparam int CM_RD = 2;
  localparam int CM_SRE = 3;
  localparam int CM_SRX = 4;
  localparam int ST_IDLE = 0;
  localparam int ST_ODT = 1;
  localparam int ST_SREF = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_READ = 4;
  localparam logic [CNT_W-1:0] RD_LEN = 6'h04;
  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_LEAD = 5'h02,
    H_HOLD = 5'h04,
    H_READ = 5'h08,
    H_SREF = 5'h10
  } dodt_hstate_t;

  function automatic logic [DIV_W-1:0] nom_div_f(input logic [NOM_W-1:0] c);
    case (c)
      3'h1:    nom_div_f = DIV4;
      3'h2:    nom_div_f = DIV2;
      3'h3:    nom_div_f = DIV6;
      3'h4:    nom_div_f = DIV12;
      3'h5:    nom_div_f = DIV8;
      default: nom_div_f = DIV_OFF;
    endcase
  endfunction

  function automatic logic [DIV_W-1:0] wr_div_f(input logic [WRS_W-1:0] c);
    case (c)
      2'h1:    wr_div_f = DIV4;
      2'h2:    wr_div_f = DIV2;
      default: wr_div_f = DIV_OFF;
    endcase
  endfunction

  function automatic logic nom_reserved_f(input logic [NOM_W-1:0] c);
    nom_reserved_f = (c == 3'h6) || (c == 3'h7);
  endfunction

  function automatic logic nom_wr_ok_f(input logic [NOM_W-1:0] c);
    logic [DIV_W-1:0] d;
    d = nom_div_f(c);
    nom_wr_ok_f = (d == DIV2) || (d == DIV4) || (d == DIV6);
  endfunction

  function automatic logic [OHM_W-1:0] ohm_f(input logic [DIV_W-1:0] d);
    if (d == DIV_OFF)
    begin
      ohm_f = 8'h00;
    end
    else
    begin
      ohm_f = OHM_W'(RZQ_OHM / int'(d));
    end
  endfunction
endpackage

// file: rtl/dodt_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dodt_link_if;
  logic                          odt;
  logic                          wr_cmd;
  logic                          wr_bl8;
  logic                          rd_active;
  logic                          self_refresh;
  logic                          dll_disable;
  logic                          dll_locked;
  logic [dodt_pkg::NOM_W-1:0]    mr1_rtt;
  logic [dodt_pkg::WRS_W-1:0]    mr2_rtt_wr;
  logic [dodt_pkg::CL_W-1:0]     cwl;
  logic [dodt_pkg::CL_W-1:0]     al;
  logic                          org_x16;
  logic                          tdqs_en;
  modport ctrl (output odt, wr_cmd, wr_bl8, rd_active, self_refresh, dll_disable, dll_locked,
                output mr1_rtt, mr2_rtt_wr, cwl, al, org_x16, tdqs_en);
  modport dram (input odt, wr_cmd, wr_bl8, rd_active, self_refresh, dll_disable, dll_locked,
                input mr1_rtt, mr2_rtt_wr, cwl, al, org_x16, tdqs_en);
endinterface
`default_nettype wire

// file: rtl/dodt_lat_line.sv
`timescale 1ns/100ps
`default_nettype none
module dodt_lat_line (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       d,
  input  wire logic [dodt_pkg::LAT_W-1:0] tap,
  output logic                            q
);
  logic [dodt_pkg::LAT_DEPTH-1:0] sr;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sr[0] <= 1'b0;
    end
    else
    begin
      sr[0] <= d;
    end
  end

  genvar i;
  generate
    for (i = 1; i < dodt_pkg::LAT_DEPTH; i++)
    begin : g_stage
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sr[i] <= 1'b0;
        end
        else
        begin
          sr[i] <= sr[i-1];
        end
      end
    end
  endgenerate

  assign q = sr[tap];
endmodule
`default_nettype wire

// file: rtl/dodt_dram_end.sv
`timescale 1ns/100ps
`default_nettype none
module dodt_dram_end (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  dodt_link_if.dram                        link,
  output logic [dodt_pkg::LANES-1:0]       lane_term,
  output logic                             term_on,
  output logic [dodt_pkg::DIV_W-1:0]       rtt_div,
  output logic [dodt_pkg::OHM_W-1:0]       rtt_ohm,
  output logic                             dyn_active,
  output logic                             sync_mode,
  output logic                             cfg_illegal,
  output logic                             wr_nom_bad,
  output logic                             proto_err
);
  logic [dodt_pkg::CNT_W-1:0] wcnt;
  logic                       wact;
  logic                       wbl8;
  logic                       odt_prev;
  logic [dodt_pkg::CNT_W-1:0] hcnt;
  logic [dodt_pkg::CNT_W-1:0] hreq;
  logic                       line_q;

  // Strength decode
  wire logic [dodt_pkg::DIV_W-1:0] nom_div = dodt_pkg::nom_div_f(link.mr1_rtt);
  wire logic [dodt_pkg::DIV_W-1:0] wr_div = dodt_pkg::wr_div_f(link.mr2_rtt_wr);
  wire logic                       dyn_en = |link.mr2_rtt_wr;
  wire logic                       reserved = dodt_pkg::nom_reserved_f(link.mr1_rtt);
  wire logic                       all_off = (nom_div == dodt_pkg::DIV_OFF) && !dyn_en;

  // Conditions under which the pin has no effect
  wire logic blocked = link.dll_disable
                     | link.self_refresh | all_off
                     | reserved;
  wire logic odt_eff = link.odt & ~blocked;

  // Latencies
  wire logic [dodt_pkg::LAT_W-1:0] wl = {1'b0, link.cwl} + {1'b0, link.al};
  wire logic [dodt_pkg::LAT_W-1:0] odtl = wl - dodt_pkg::ODTL_SUB;
  wire logic [dodt_pkg::LAT_W-1:0] tap = odtl - 5'h01;
  wire logic [dodt_pkg::CNT_W-1:0] cnw = {1'b0, odtl};

  dodt_lat_line u_line (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (odt_eff),
    .tap     (tap),
    .q       (line_q)
  );

  // Locked DLL follows the latency line, otherwise the pin directly
  wire logic next_sync = link.dll_locked;
  wire logic next_on = blocked ? 1'b0 : (next_sync ? line_q : odt_eff);

  // Write burst tracking
  wire logic [dodt_pkg::CNT_W-1:0] cnt_inc = (&wcnt) ? wcnt : wcnt + 6'h01;
  wire logic [dodt_pkg::CNT_W-1:0] next_wcnt = link.wr_cmd ? 6'h00 : cnt_inc;
  wire logic                       next_bl8 = link.wr_cmd ? link.wr_bl8 : wbl8;
  wire logic [dodt_pkg::CNT_W-1:0] burst_h = next_bl8 ? dodt_pkg::ODTH8 : dodt_pkg::ODTH4;
  wire logic [dodt_pkg::CNT_W-1:0] cwn = cnw + burst_h;
  wire logic                       next_act = link.wr_cmd | (wact & (next_wcnt < cwn));
  wire logic                       next_win = next_act & dyn_en & ~link.dll_disable
                                            & (next_wcnt >= cnw) & (next_wcnt < cwn);

  // Selected strength, none when terminated lines are off
  wire logic [dodt_pkg::DIV_W-1:0] sel_div = next_win ? wr_div : nom_div;
  wire logic [dodt_pkg::DIV_W-1:0] next_div = next_on ? sel_div : dodt_pkg::DIV_OFF;
  wire logic next_bad = next_on & next_act & ~dyn_en & ~dodt_pkg::nom_wr_ok_f(link.mr1_rtt);

  // Host protocol watch
  wire logic rise = link.odt & ~odt_prev;
  wire logic wr_hi = link.wr_cmd & link.odt;
  wire logic fall = ~link.odt & odt_prev;
  wire logic hold_short = fall & (hcnt < hreq);
  wire logic rd_odt = link.rd_active & link.odt;
  wire logic sr_odt = link.self_refresh & link.odt;
  wire logic [dodt_pkg::CNT_W-1:0] req_w = link.wr_bl8 ? dodt_pkg::ODTH8 : dodt_pkg::ODTH4;
  wire logic [dodt_pkg::CNT_W-1:0] next_hreq = wr_hi ? req_w : (rise ? dodt_pkg::ODTH4 : hreq);
  wire logic [dodt_pkg::CNT_W-1:0] hinc = (&hcnt) ? hcnt : hcnt + 6'h01;
  wire logic [dodt_pkg::CNT_W-1:0] next_hcnt = (wr_hi | rise) ? 6'h01 : hinc;

  // Lane presence per organisation
  function automatic logic lane_used(input int n, input logic x16, input logic tdqs);
    case (n)
      dodt_pkg::LN_DQ, dodt_pkg::LN_LDQS, dodt_pkg::LN_LDM: lane_used = 1'b1;
      dodt_pkg::LN_TDQS: lane_used = ~x16 & tdqs;
      dodt_pkg::LN_UDQS, dodt_pkg::LN_UDM: lane_used = x16;
      default: lane_used = 1'b0;
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < dodt_pkg::LANES; g++)
    begin : g_lane
      wire logic next_lane = (next_div != dodt_pkg::DIV_OFF) & lane_used(g, link.org_x16, link.tdqs_en);
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          lane_term[g] <= 1'b0;
        end
        else
        begin
          lane_term[g] <= next_lane;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      term_on <= 1'b0;
      rtt_div <= dodt_pkg::DIV_OFF;
      rtt_ohm <= '0;
      dyn_active <= 1'b0;
      sync_mode <= 1'b0;
    end
    else
    begin
      term_on <= next_on & (sel_div != dodt_pkg::DIV_OFF);
      rtt_div <= next_div;
      rtt_ohm <= dodt_pkg::ohm_f(next_div);
      dyn_active <= next_win;
      sync_mode <= next_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wcnt <= '1;
      wact <= 1'b0;
      wbl8 <= 1'b0;
    end
    else
    begin
      wcnt <= next_wcnt;
      wact <= next_act;
      wbl8 <= next_bl8;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_illegal <= 1'b0;
      wr_nom_bad <= 1'b0;
      proto_err <= 1'b0;
    end
    else
    begin
      cfg_illegal <= reserved;
      wr_nom_bad <= next_bad;
      proto_err <= hold_short | rd_odt | sr_odt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      odt_prev <= 1'b0;
      hcnt <= '1;
      hreq <= '0;
    end
    else
    begin
      odt_prev <= link.odt;
      hcnt <= next_hcnt;
      hreq <= next_hreq;
    end
  end
endmodule
`default_nettype wire

// file: rtl/dodt_ctrl_end.sv
`timescale 1ns/100ps
`default_nettype none
module dodt_ctrl_end (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  dodt_link_if.ctrl        link
);
  logic [dodt_pkg::CFG_W-1:0]  cfg;
  dodt_pkg::dodt_hstate_t      st;
  logic [dodt_pkg::CNT_W-1:0]  cnt;
  logic                        bl8;
  logic                        refused;

  wire logic setup = psel & ~penable;
  wire logic acc_wr = psel & penable & pwrite;
  wire logic hit_cfg = paddr == dodt_pkg::A_CFG;
  wire logic hit_cmd = paddr == dodt_pkg::A_CMD;
  wire logic hit_stat = paddr == dodt_pkg::A_STAT;
  wire logic mapped = hit_cfg | hit_cmd | hit_stat;
  wire logic cmd_go = acc_wr & hit_cmd;
  wire logic c_wr = cmd_go & pwdata[dodt_pkg::CM_WR];
  wire logic c_rd = cmd_go & pwdata[dodt_pkg::CM_RD];
  wire logic c_sre = cmd_go & pwdata[dodt_pkg::CM_SRE];
  wire logic c_srx = cmd_go & pwdata[dodt_pkg::CM_SRX];
  wire logic is_idle = st == dodt_pkg::H_IDLE;
  wire logic is_sref = st == dodt_pkg::H_SREF;
  wire logic accepted = (is_idle & (c_wr | c_rd | c_sre)) | (is_sref & c_srx);
  wire logic any_cmd = c_wr | c_rd | c_sre | c_srx;
  wire logic clr_ref = acc_wr & hit_stat & pwdata[dodt_pkg::ST_REFUSED];

  wire logic [dodt_pkg::NOM_W-1:0] nom = cfg[dodt_pkg::CF_NOM +: dodt_pkg::NOM_W];
  wire logic [dodt_pkg::WRS_W-1:0] wrs = cfg[dodt_pkg::CF_WRS +: dodt_pkg::WRS_W];
  wire logic dyn_en = |wrs;
  wire logic nom_ok = dyn_en | (nom == 3'h0) | dodt_pkg::nom_wr_ok_f(nom);
  wire logic term_ok = cfg[dodt_pkg::CF_INIT]
                     & ~cfg[dodt_pkg::CF_DLLDIS]
                     & ~dodt_pkg::nom_reserved_f(nom)
                     & ((nom != 3'h0) | dyn_en) & nom_ok;
  wire logic [dodt_pkg::CNT_W-1:0] hold_n = (bl8 ? dodt_pkg::ODTH8 : dodt_pkg::ODTH4) - 6'h01;

  wire logic [31:0] stat_w = {27'h0, st == dodt_pkg::H_READ, refused, is_sref, link.odt, is_idle};
  wire logic [31:0] rd_mux = hit_cfg ? {14'h0, cfg} : (hit_stat ? stat_w : 32'h0);

  assign pready = 1'b1;
  assign link.mr1_rtt = nom;
  assign link.mr2_rtt_wr = wrs;
  assign link.cwl = cfg[dodt_pkg::CF_CWL +: dodt_pkg::CL_W];
  assign link.al = cfg[dodt_pkg::CF_AL +: dodt_pkg::CL_W];
  assign link.dll_disable = cfg[dodt_pkg::CF_DLLDIS];
  assign link.dll_locked = cfg[dodt_pkg::CF_LOCK];
  assign link.org_x16 = cfg[dodt_pkg::CF_X16];
  assign link.tdqs_en = cfg[dodt_pkg::CF_TDQS];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg <= dodt_pkg::CFG_RST;
      prdata <= 32'h0;
      pslverr <= 1'b0;
      refused <= 1'b0;
    end
    else
    begin
      if (acc_wr & hit_cfg)
      begin
        cfg <= pwdata[dodt_pkg::CFG_W-1:0];
      end
      if (setup)
      begin
        prdata <= pwrite ? 32'h0 : rd_mux;
        pslverr <= ~mapped;
      end
      refused <= (any_cmd & ~accepted) | (refused & ~clr_ref);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= dodt_pkg::H_IDLE;
      cnt <= '0;
      bl8 <= 1'b0;
      link.odt <= 1'b0;
      link.wr_cmd <= 1'b0;
      link.wr_bl8 <= 1'b0;
      link.rd_active <= 1'b0;
      link.self_refresh <= 1'b0;
    end
    else
    begin
      case (st)
        dodt_pkg::H_IDLE:
        begin
          if (c_wr)
          begin
            link.odt <= term_ok;
            bl8 <= pwdata[dodt_pkg::CM_BL8];
            st <= dodt_pkg::H_LEAD;
          end
          else if (c_rd)
          begin
            link.rd_active <= 1'b1;
            cnt <= dodt_pkg::RD_LEN - 6'h01;
            st <= dodt_pkg::H_READ;
          end
          else if (c_sre)
          begin
            link.self_refresh <= 1'b1;
            st <= dodt_pkg::H_SREF;
          end
        end
        dodt_pkg::H_LEAD:
        begin
          link.wr_cmd <= 1'b1;
          link.wr_bl8 <= bl8;
          cnt <= hold_n;
          st <= dodt_pkg::H_HOLD;
        end
        dodt_pkg::H_HOLD:
        begin
          link.wr_cmd <= 1'b0;
          if (cnt == 6'h00)
          begin
            link.odt <= 1'b0;
            st <= dodt_pkg::H_IDLE;
          end
          else
          begin
            cnt <= cnt - 6'h01;
          end
        end
        dodt_pkg::H_READ:
        begin
          if (cnt == 6'h00)
          begin
            link.rd_active <= 1'b0;
            st <= dodt_pkg::H_IDLE;
          end
          else
          begin
            cnt <= cnt - 6'h01;
          end
        end
        dodt_pkg::H_SREF:
        begin
          if (c_srx)
          begin
            link.self_refresh <= 1'b0;
            st <= dodt_pkg::H_IDLE;
          end
        end
        default:
        begin
          st <= dodt_pkg::H_IDLE;
          link.odt <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: test/dodt_link_chk.sv
`timescale 1ns/100ps
`default_nettype none
module dodt_link_chk (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       odt,
  input wire logic                       wr_cmd,
  input wire logic                       wr_bl8,
  input wire logic                       dll_disable,
  input wire logic                       dll_locked,
  input wire logic                       self_refresh,
  input wire logic [dodt_pkg::NOM_W-1:0] mr1_rtt,
  input wire logic [dodt_pkg::CL_W-1:0]  cwl,
  input wire logic [dodt_pkg::CL_W-1:0]  al,
  input wire logic                       term_on,
  input wire logic [dodt_pkg::DIV_W-1:0] rtt_div,
  input wire logic [dodt_pkg::OHM_W-1:0] rtt_ohm,
  input wire logic                       dyn_active,
  input wire logic                       sync_mode,
  input wire logic                       cfg_illegal
);
  logic [39:0] odt_h;
  logic [39:0] wr_h;
  logic [39:0] bl_h;
  logic [5:0]  lat;

  assign lat = {2'b00, cwl} + {2'b00, al} - 6'h02;

  // Link history, newest sample in bit 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      odt_h <= '0;
      wr_h  <= '0;
      bl_h  <= '0;
    end
    else
    begin
      odt_h <= {odt_h[38:0], odt};
      wr_h  <= {wr_h[38:0], wr_cmd};
      bl_h  <= {bl_h[38:0], wr_bl8};
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_resv; mr1_rtt[2:1] == 2'b11 |=> cfg_illegal; endproperty
  a_resv: assert property (p_resv) else $error("reserved code not flagged");
  property p_dis; dll_disable |=> !term_on && !dyn_active; endproperty
  a_dis: assert property (p_dis) else $error("termination with dll disabled");
  property p_async;
    $rose(odt) && !dll_locked && !dll_disable && !self_refresh && mr1_rtt inside {[3'h1:3'h5]} |=> term_on;
  endproperty
  a_async: assert property (p_async) else $error("async turn-on late");
  property p_on; $rose(term_on) && sync_mode && !dyn_active |-> odt_h[lat] && !odt_h[lat+6'h01]; endproperty
  a_on: assert property (p_on) else $error("turn-on latency wrong");
  property p_off;
    $fell(term_on) && sync_mode && !$past(dyn_active) && !$past(self_refresh) && !$past(dll_disable)
      |-> !odt_h[lat] && odt_h[lat+6'h01];
  endproperty
  a_off: assert property (p_off) else $error("turn-off latency wrong");
  property p_don; $rose(dyn_active) |-> wr_h[lat]; endproperty
  a_don: assert property (p_don) else $error("write strength start wrong");
  property p_doff;
    $fell(dyn_active) |-> (wr_h[lat+6'h06] && bl_h[lat+6'h06]) || (wr_h[lat+6'h04] && !bl_h[lat+6'h04]);
  endproperty
  a_doff: assert property (p_doff) else $error("write strength end wrong");
  property p_h8; wr_cmd && wr_bl8 && odt |-> odt[*6] ##1 !odt; endproperty
  a_h8: assert property (p_h8) else $error("odt hold after bl8 write wrong");
  property p_h4; wr_cmd && !wr_bl8 && odt |-> odt[*4] ##1 !odt; endproperty
  a_h4: assert property (p_h4) else $error("odt hold after bc4 write wrong");
  property p_ohm; term_on |-> {4'h0, rtt_ohm} * {8'h00, rtt_div} == 12'h0F0; endproperty
  a_ohm: assert property (p_ohm) else $error("strength not reference divided");

  c_dyn: cover property (dyn_active && term_on);
  c_resv: cover property (cfg_illegal);
  c_async: cover property (!sync_mode && term_on);
endmodule
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  lane_term;
  logic        term_on;
  logic [3:0]  rtt_div;
  logic [7:0]  rtt_ohm;
  logic        dyn_active;
  logic        sync_mode;
  logic        cfg_illegal;
  logic        wr_nom_bad;
  logic        proto_err;
  logic [31:0] rdat;
  logic        rerr;
  int          fail_count;
  int          comparisons;
  int          ons;
  logic [3:0]  ndiv [6] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hC, 4'h8};

  dodt_link_if link ();
  dodt_ctrl_end u_dodt_ctrl_end (
    .pclk (pclk), .presetn (presetn), .psel (psel), .penable (penable), .pwrite (pwrite),
    .paddr (paddr), .pwdata (pwdata), .prdata (prdata), .pready (pready), .pslverr (pslverr),
    .link (link)
  );
  dodt_dram_end u_dodt_dram_end (
    .pclk (pclk), .presetn (presetn), .link (link), .lane_term (lane_term), .term_on (term_on),
    .rtt_div (rtt_div), .rtt_ohm (rtt_ohm), .dyn_active (dyn_active), .sync_mode (sync_mode),
    .cfg_illegal (cfg_illegal), .wr_nom_bad (wr_nom_bad), .proto_err (proto_err)
  );
  dodt_link_chk u_dodt_link_chk (
    .pclk (pclk), .presetn (presetn), .odt (link.odt), .wr_cmd (link.wr_cmd), .wr_bl8 (link.wr_bl8),
    .dll_disable (link.dll_disable), .dll_locked (link.dll_locked), .self_refresh (link.self_refresh),
    .mr1_rtt (link.mr1_rtt), .cwl (link.cwl), .al (link.al), .term_on (term_on), .rtt_div (rtt_div),
    .rtt_ohm (rtt_ohm), .dyn_active (dyn_active), .sync_mode (sync_mode), .cfg_illegal (cfg_illegal)
  );

  always #10 pclk = ~pclk;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Config word: flags are {tdqs_en, x16, dll_locked, dll_disable}, init always done
  function automatic logic [31:0] cw(input logic [2:0] n, input logic [1:0] w, input logic [3:0] c,
                                     input logic [3:0] a, input logic [3:0] f);
    cw = {14'h0000, 1'b1, f, a, c, w, n};
  endfunction

  // Issue one write and watch strength and lanes while terminated
  task automatic wr(input logic b8, input logic [3:0] nd, input logic [3:0] wd, input logic [5:0] ln,
                    input logic on);
    apb(1'b1, dodt_pkg::A_CMD, {30'h0, b8, 1'b1});
    ons = 0;
    repeat (30)
    begin
      @(negedge pclk);
      if (term_on === 1'b1)
      begin
        ons++;
        chk("rtt_div", {28'h0, (dyn_active === 1'b1) ? wd : nd}, {28'h0, rtt_div});
        chk("lane_term", {26'h0, ln}, {26'h0, lane_term});
      end
      chk("wr_nom_bad", 32'h0, {31'h0, wr_nom_bad});
      chk("proto_err", 32'h0, {31'h0, proto_err});
    end
    chk("term_seen", {31'h0, on}, {31'h0, ons > 0});
  endtask

  task automatic final_report;
    $display("fail_count %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    final_report();
  end

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    comparisons = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, dodt_pkg::A_CFG, 32'h0);
    chk("cfg_reset", 32'h000A0, rdat);
    apb(1'b0, dodt_pkg::A_STAT, 32'h0);
    chk("stat_reset", 32'h00000001, rdat);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    // x8 with extra strobe, nominal only
    apb(1'b1, dodt_pkg::A_CFG, cw(3'h1, 2'h0, 4'h5, 4'h0, 4'hA));
    wr(1'b1, 4'h4, 4'h0, 6'h0F, 1'b1);
    chk("sync_mode", 32'h1, {31'h0, sync_mode});
    // x16, dynamic /2 over nominal codes 1 to 5
    for (int c = 1; c < 6; c++)
    begin
      apb(1'b1, dodt_pkg::A_CFG, cw(3'(c), 2'h2, 4'h6, 4'h1, 4'h6));
      wr(c[0], ndiv[c], 4'h2, 6'h37, 1'b1);
    end
    apb(1'b1, dodt_pkg::A_CFG, cw(3'h4, 2'h0, 4'h5, 4'h0, 4'h2));
    wr(1'b1, 4'h0, 4'h0, 6'h00, 1'b0);
    apb(1'b1, dodt_pkg::A_CFG, cw(3'h0, 2'h1, 4'h5, 4'h0, 4'h2));
    wr(1'b0, 4'h0, 4'h4, 6'h07, 1'b1);
    apb(1'b1, dodt_pkg::A_CFG, cw(3'h6, 2'h0, 4'h5, 4'h0, 4'h2));
    wr(1'b1, 4'h0, 4'h0, 6'h00, 1'b0);
    chk("cfg_illegal", 32'h1, {31'h0, cfg_illegal});
    apb(1'b1, dodt_pkg::A_CFG, cw(3'h2, 2'h0, 4'h5, 4'h0, 4'h2));
    apb(1'b1, dodt_pkg::A_CMD, 32'h4);
    apb(1'b0, dodt_pkg::A_STAT, 32'h0);
    chk("stat_read", 32'h10, rdat);
    repeat (6) @(posedge pclk);
    apb(1'b1, dodt_pkg::A_CMD, 32'h8);
    apb(1'b1, dodt_pkg::A_CMD, 32'h1);
    apb(1'b0, dodt_pkg::A_STAT, 32'h0);
    chk("stat_refused", 32'h0C, rdat);
    chk("term_sref", 32'h0, {31'h0, term_on});
    apb(1'b1, dodt_pkg::A_STAT, 32'h8);
    apb(1'b0, dodt_pkg::A_STAT, 32'h0);
    chk("stat_clear", 32'h04, rdat);
    apb(1'b1, dodt_pkg::A_CMD, 32'h10);
    apb(1'b0, dodt_pkg::A_STAT, 32'h0);
    chk("stat_exit", 32'h01, rdat);
    // Init not done: controller keeps the pin low
    apb(1'b1, dodt_pkg::A_CFG, cw(3'h2, 2'h0, 4'h5, 4'h0, 4'h2) ^ 32'h00020000);
    wr(1'b1, 4'h0, 4'h0, 6'h00, 1'b0);
    // DLL unlocked, then disabled
    apb(1'b1, dodt_pkg::A_CFG, cw(3'h2, 2'h0, 4'h5, 4'h0, 4'h0));
    repeat (3) @(posedge pclk);
    wr(1'b1, 4'h2, 4'h0, 6'h07, 1'b1);
    chk("sync_mode", 32'h0, {31'h0, sync_mode});
    apb(1'b1, dodt_pkg::A_CFG, cw(3'h2, 2'h1, 4'h5, 4'h0, 4'h1));
    wr(1'b1, 4'h0, 4'h0, 6'h00, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
